// file: hdl/fswp_top.sv
// status registers and write protection of a serial NOR flash core
// assumes commands arrive decoded and framed, one pulse per command
// Functional notes
// - low byte: guard0, block-protect 4..0, write latch, busy; latch and busy read-only
// - high byte: erase-susp, complement, locks 3..1, prog-susp, quad, guard1
// - busy reads one while program, erase or status write runs
// - write latch visible; cleared latch refuses status write, program, erase
// - block-protect bits non-volatile, changed only by status write
// - program, sector and block erase into protected region are blocked
// - block-protect accepted only outside hardware-protected mode
// - chip erase only if bp2..0 zero with cmp 0 or ones with cmp 1
// - guards 00: status write allowed when latch set, pin ignored
// - guards 01 with pin low: status register locked
// - guards 01 with pin high: status write allowed after latch set
// - guards 10: status writes refused until power cycle
// - guards 10 return to 00 on power cycle
// - guards 11: status writes refused permanently
// - quad 0: shared pins are protect and hold; quad 1: data lines
// - security locks default zero, each settable alone by status write
// - security locks one-time: never cleared, then regions read-only
// - complement bit non-volatile, default zero, combined with block-protect
// - complement set protects the complement of the plain region
// - write-enable sets latch; reset, disable, accepted writes, programs, erases clear it
// - suspend sets its flag; resume, soft reset, power cycle clear both
`timescale 1ns/100ps
module fswp_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_power_cycle,
  input wire fswp_pkg::fswp_cmd_t i_cmd,
  input wire logic [7:0] i_wlow,
  input wire logic [7:0] i_whigh,
  input wire logic [fswp_pkg::FSWP_AW-1:0] i_addr_lo,
  input wire logic [fswp_pkg::FSWP_AW-1:0] i_addr_hi,
  input wire logic i_op_done,
  input wire logic i_protect_pin_n,
  output logic [7:0] o_status_protect_low,
  output logic [7:0] o_status_control_high,
  output logic o_op_start,
  output logic o_op_refused,
  output logic o_quad_enable,
  output logic o_secure_ro_1,
  output logic o_secure_ro_2,
  output logic o_secure_ro_3
);
  import fswp_pkg::*;
  // ************************************
  // pin synchroniser
  // ************************************
  logic pin_s1;
  logic pin_s2;
  // two stages before the protect pin is read
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end
    else
    begin
      pin_s1 <= i_protect_pin_n;
      pin_s2 <= pin_s1;
    end
  end
  // ************************************
  // volatile state
  // ************************************
  fswp_state_t state;
  fswp_state_t next_state;
  logic wr_latch;
  logic next_wr_latch;
  logic esus;
  logic psus;
  logic [3:0] wcnt;
  logic busy_status;
  logic [7:0] pend_low;
  logic [7:0] pend_high;
  logic [7:0] nv_low;
  logic [7:0] nv_high;
  logic nv_we;
  logic guard0;
  logic guard1;
  logic compl;
  logic [4:0] bp;
  logic [2:0] lock;
  logic region_hit;
  assign guard0 = nv_low[FSWP_B_GUARD0];
  assign guard1 = nv_high[FSWP_B_GUARD1];
  assign compl = nv_high[FSWP_B_COMPL];
  assign bp = nv_low[FSWP_B_BP_LO +: 5];
  assign lock = nv_high[FSWP_B_LOCK_LO +: 3];
  // ************************************
  // command qualification
  // ************************************
  logic idle;
  logic is_write;
  logic is_area;
  logic is_chip;
  logic hw_locked;
  logic pin_high;
  logic sr_open;
  logic chip_ok;
  logic area_ok;
  logic stat_ok;
  logic start_op;
  assign idle = (state == FSWP_ST_IDLE);
  assign is_write = (i_cmd == FSWP_CMD_WSTAT);
  assign is_area = (i_cmd == FSWP_CMD_PROG) | (i_cmd == FSWP_CMD_SECT) |
                   (i_cmd == FSWP_CMD_BLK);
  assign is_chip = (i_cmd == FSWP_CMD_CHIP);
  // protect pin has no say once it carries quad data
  assign pin_high = pin_s2 | nv_high[FSWP_B_QUAD];
  assign hw_locked = !guard1 & guard0 & !pin_high;
  // guard modes: 00 open 01 pin-gated 1x closed
  assign sr_open = !guard1 & (!guard0 | pin_high);
  assign chip_ok = (!compl & (bp[2:0] == 3'b000)) | (compl & (bp[2:0] == 3'b111));
  assign area_ok = !region_hit;
  assign stat_ok = is_write & wr_latch & sr_open;
  assign start_op = idle & wr_latch & ((is_area & area_ok) | (is_chip & chip_ok) | stat_ok);
  assign o_op_start = start_op & !is_write;
  assign o_op_refused = idle & (is_area | is_chip | is_write) & !start_op;
  fswp_region u_region (
    .i_bp(bp),
    .i_compl(compl),
    .i_addr_lo(i_addr_lo),
    .i_addr_hi(i_addr_hi),
    .o_hit(region_hit)
  );
  // ************************************
  // write-enable latch
  // ************************************
  always_comb
  begin
    next_wr_latch = wr_latch;
    if (i_cmd == FSWP_CMD_WEN)
      next_wr_latch = 1'b1;
    if ((i_cmd == FSWP_CMD_WDIS) | (i_cmd == FSWP_CMD_SRST) | start_op)
      next_wr_latch = 1'b0;
  end
  // latch register, supply loss drops it
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      wr_latch <= 1'b0;
    else if (i_power_cycle)
      wr_latch <= 1'b0;
    else
      wr_latch <= next_wr_latch;
  end
  // ************************************
  // busy sequencer
  // ************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      FSWP_ST_IDLE: if (start_op) next_state = FSWP_ST_BUSY;
      FSWP_ST_BUSY: if (busy_status ? (wcnt == 4'h1) : i_op_done) next_state = FSWP_ST_IDLE;
      default: next_state = FSWP_ST_IDLE;
    endcase
  end
  // busy flag and status write timer
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= FSWP_ST_IDLE;
      busy_status <= 1'b0;
      wcnt <= 4'h0;
      pend_low <= FSWP_LOW_RST;
      pend_high <= FSWP_HIGH_RST;
    end
    else if (i_power_cycle | (i_cmd == FSWP_CMD_SRST))
    begin
      state <= FSWP_ST_IDLE;
      busy_status <= 1'b0;
      wcnt <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (start_op)
      begin
        busy_status <= is_write;
        wcnt <= 4'(FSWP_WRITE_CYC);
        pend_low <= i_wlow;
        pend_high <= i_whigh;
      end
      else if (wcnt != 4'h0)
        wcnt <= wcnt - 4'h1;
    end
  end
  // ************************************
  // non-volatile bits
  // ************************************
  logic commit;
  assign commit = !idle & busy_status & (wcnt == 4'h1);
  // block-protect held while pin-locked
  logic [7:0] low_we;
  logic [7:0] high_we;
  assign low_we = {8{commit}} & FSWP_LOW_WMASK & {1'b1, {5{!hw_locked}}, 2'b00};
  assign high_we = {8{commit}} & FSWP_HIGH_WMASK;
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_nv
      fswp_bitcell #(
        .RST_VAL(FSWP_LOW_RST[g]),
        .OTP(1'b0)
      ) u_low (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(low_we[g]),
        .i_d(pend_low[g]),
        .o_q(nv_low[g])
      );
      // locks are one-time cells
      fswp_bitcell #(
        .RST_VAL(FSWP_HIGH_RST[g]),
        .OTP((g >= FSWP_B_LOCK_LO) && (g < FSWP_B_COMPL))
      ) u_high (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(high_we[g] | (i_power_cycle & (g == FSWP_B_GUARD1) & guard1 & !guard0)),
        .i_d(i_power_cycle ? 1'b0 : pend_high[g]),
        .o_q(nv_high[g])
      );
    end
  endgenerate
  // power cycle drops lock-down guard1 only, guard0 is left alone
  // guard0 is already 0 in that mode, so only guard1 needs clearing
  // ************************************
  // suspend flags
  // ************************************
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      esus <= 1'b0;
      psus <= 1'b0;
    end
    else if (i_power_cycle | (i_cmd == FSWP_CMD_RES) | (i_cmd == FSWP_CMD_SRST))
    begin
      esus <= 1'b0;
      psus <= 1'b0;
    end
    else
    begin
      esus <= esus | (i_cmd == FSWP_CMD_ESUS);
      psus <= psus | (i_cmd == FSWP_CMD_PSUS);
    end
  end
  // ************************************
  // status outputs
  // ************************************
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_status_protect_low <= FSWP_LOW_RST;
      o_status_control_high <= FSWP_HIGH_RST;
      o_quad_enable <= 1'b0;
      o_secure_ro_1 <= 1'b0;
      o_secure_ro_2 <= 1'b0;
      o_secure_ro_3 <= 1'b0;
    end
    else
    begin
      o_status_protect_low <= {nv_low[7:2], wr_latch, !idle};
      o_status_control_high <= {esus, nv_high[6:3], psus, nv_high[1:0]};
      o_quad_enable <= nv_high[FSWP_B_QUAD];
      o_secure_ro_1 <= lock[0];
      o_secure_ro_2 <= lock[1];
      o_secure_ro_3 <= lock[2];
    end
  end
  // ************************************
  // checks
  // ************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_NO_LATCH_NO_START: assert property (!wr_latch |-> !start_op)
    else $error("operation started without write latch");
  AST_BUSY_AFTER_START: assert property (start_op && !i_power_cycle
      && i_cmd != FSWP_CMD_SRST |=> ##1 o_status_protect_low[0])
    else $error("busy not shown after start");
  AST_LATCH_CLEARED: assert property (start_op && i_cmd != FSWP_CMD_WEN |=> !wr_latch)
    else $error("latch not cleared by operation");
  AST_ENABLE_SETS: assert property (i_cmd == FSWP_CMD_WEN && !i_power_cycle |=> wr_latch)
    else $error("write enable did not set latch");
  AST_REGION_BLOCK: assert property (is_area && region_hit |-> !o_op_start)
    else $error("protected region operation started");
  AST_CHIP_GATE: assert property (is_chip && !chip_ok |-> !o_op_start)
    else $error("chip erase started while protected");
  AST_GUARD_CLOSED: assert property (guard1 && is_write |-> !start_op)
    else $error("status write accepted while guarded");
  AST_PIN_LOCK: assert property (!guard1 && guard0 && !pin_high && is_write |-> !start_op)
    else $error("status write accepted while pin-locked");
  AST_LOCK_STICKY: assert property (lock[0] |=> lock[0])
    else $error("security lock cleared");
  AST_REFUSE_IDLE: assert property (o_op_refused && !i_power_cycle |=> idle)
    else $error("refused operation set busy");
  AST_RESUME_CLR: assert property (i_cmd == FSWP_CMD_RES |=> !esus && !psus)
    else $error("resume did not clear suspend");
endmodule

// file: hdl/fswp_pkg.sv
// package for the flash status and write-protection block
// assumes one 10 MHz clock domain and a decoded command interface
package fswp_pkg;
  // ************************************
  // status bit positions, low byte
  // ************************************
  localparam int FSWP_B_BUSY = 0;
  localparam int FSWP_B_LATCH = 1;
  localparam int FSWP_B_BP_LO = 2;
  localparam int FSWP_B_GUARD0 = 7;
  // ************************************
  // status bit positions, high byte (index within byte)
  // ************************************
  localparam int FSWP_B_GUARD1 = 0;
  localparam int FSWP_B_QUAD = 1;
  localparam int FSWP_B_PSUS = 2;
  localparam int FSWP_B_LOCK_LO = 3;
  localparam int FSWP_B_COMPL = 6;
  localparam int FSWP_B_ESUS = 7;
  // ************************************
  // defaults and geometry
  // ************************************
  localparam logic [7:0] FSWP_LOW_RST = 8'h00;
  localparam logic [7:0] FSWP_HIGH_RST = 8'h00;
  localparam logic [7:0] FSWP_LOW_WMASK = 8'hFC;
  localparam logic [7:0] FSWP_HIGH_WMASK = 8'h7B;
  localparam int FSWP_AW = 18;
  localparam logic [17:0] FSWP_TOP_ADDR = 18'h3FFFF;
  localparam int FSWP_WRITE_NS = 500;
  localparam int FSWP_CLK_NS = 100;
  localparam int FSWP_WRITE_CYC = (FSWP_WRITE_NS + FSWP_CLK_NS - 1) / FSWP_CLK_NS;
  // ************************************
  // commands and operation kinds
  // ************************************
  typedef enum logic [3:0] {
    FSWP_CMD_NONE = 4'h0,
    FSWP_CMD_WEN = 4'h1,
    FSWP_CMD_WDIS = 4'h2,
    FSWP_CMD_WSTAT = 4'h3,
    FSWP_CMD_PROG = 4'h4,
    FSWP_CMD_SECT = 4'h5,
    FSWP_CMD_BLK = 4'h6,
    FSWP_CMD_CHIP = 4'h7,
    FSWP_CMD_ESUS = 4'h8,
    FSWP_CMD_PSUS = 4'h9,
    FSWP_CMD_RES = 4'hA,
    FSWP_CMD_SRST = 4'hB
  } fswp_cmd_t;
  typedef enum logic [1:0] {
    FSWP_ST_IDLE = 2'b00,
    FSWP_ST_BUSY = 2'b01
  } fswp_state_t;
endpackage

// file: hdl/fswp_region.sv
// protected-region decoder for the 256KB array
// assumes block-protect and complement bits are stable register outputs
`timescale 1ns/100ps
module fswp_region (
  input wire logic [4:0] i_bp,
  input wire logic i_compl,
  input wire logic [fswp_pkg::FSWP_AW-1:0] i_addr_lo,
  input wire logic [fswp_pkg::FSWP_AW-1:0] i_addr_hi,
  output logic o_hit
);
  import fswp_pkg::*;
  // ************************************
  // uncomplemented region bounds
  // ************************************
  logic [17:0] size;
  logic [17:0] base_lo;
  logic [17:0] base_hi;
  logic none;
  logic all;
  logic lower;
  logic [2:0] sel;
  assign lower = i_bp[3];
  assign sel = i_bp[2:0];
  // region size in bytes, minus one
  always_comb
  begin
    none = 1'b0;
    all = 1'b0;
    size = 18'h00000;
    if (!i_bp[4])
    begin
      unique case (i_bp[1:0])
        2'b00: none = 1'b1;
        2'b01: size = 18'h0FFFF;
        2'b10: size = 18'h1FFFF;
        2'b11: all = 1'b1;
      endcase
    end
    else
    begin
      unique case (sel)
        3'b000: none = 1'b1;
        3'b001: size = 18'h00FFF;
        3'b010: size = 18'h01FFF;
        3'b011: size = 18'h03FFF;
        3'b111: all = 1'b1;
        default: size = 18'h07FFF;
      endcase
    end
  end
  assign base_lo = lower ? 18'h00000 : FSWP_TOP_ADDR - size;
  assign base_hi = lower ? size : FSWP_TOP_ADDR;
  // overlap test; under complement, any part outside the region hits
  logic in_region;
  logic outside;
  assign in_region = all | (!none & (i_addr_hi >= base_lo) & (i_addr_lo <= base_hi));
  assign outside = none | (!all & ((i_addr_lo < base_lo) | (i_addr_hi > base_hi)));
  assign o_hit = i_compl ? outside : in_region;
endmodule

// file: hdl/fswp_bitcell.sv
// one non-volatile status bit with its own write gate
// assumes the power-cycle pulse models the loss of supply
`timescale 1ns/100ps
module fswp_bitcell #(
  parameter logic RST_VAL = 1'b0,
  parameter logic OTP = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic i_d,
  output logic o_q
);
  // one-time cells only ever move to one
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_q <= RST_VAL;
    else if (i_we)
      o_q <= OTP ? (o_q | i_d) : i_d;
  end
endmodule

// file: sim/fswp_host.sv
// host model: drives decoded flash commands and array completion
// assumes the core samples its inputs on the rising edge of i_clk
`timescale 1ns/100ps
module fswp_host (
  input wire logic i_clk,
  output fswp_pkg::fswp_cmd_t o_cmd,
  output logic [7:0] o_wlow,
  output logic [7:0] o_whigh,
  output logic [17:0] o_addr_lo,
  output logic [17:0] o_addr_hi,
  output logic o_op_done
);
  import fswp_pkg::*;
  // ************************************
  // command pulses
  // ************************************
  // quiet bus at time zero
  initial
  begin
    o_cmd = FSWP_CMD_NONE;
    o_wlow = 8'h5A;
    o_whigh = 8'hA5;
    o_addr_lo = 18'h0;
    o_addr_hi = 18'h0;
    o_op_done = 1'b0;
  end
  // raise one command just after a falling edge
  task automatic send(input fswp_cmd_t c, input logic [7:0] lo, hi, input logic [17:0] a, b);
    @(negedge i_clk);
    o_cmd = c;
    o_wlow = lo;
    o_whigh = hi;
    o_addr_lo = a;
    o_addr_hi = b;
    #1;
  endtask
  // end the pulse; stale data inverted so nothing leans on it
  task automatic rel();
    @(negedge i_clk);
    o_cmd = FSWP_CMD_NONE;
    o_wlow = ~o_wlow;
    o_whigh = ~o_whigh;
    o_addr_lo = ~o_addr_lo;
    o_addr_hi = ~o_addr_hi;
  endtask
  // array reports the end of its operation
  task automatic done();
    @(negedge i_clk);
    o_op_done = 1'b1;
    @(negedge i_clk);
    o_op_done = 1'b0;
  endtask
endmodule

// file: sim/fswp_top_tb.sv
// testbench for the status and write-protection block
// assumes the host model in fswp_host and one 10 MHz clock
`timescale 1ns/100ps
module fswp_top_tb;
  import fswp_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_power_cycle = 1'b0;
  logic i_protect_pin_n = 1'b1;
  fswp_cmd_t cmd;
  logic [7:0] wlow, whigh, low, high;
  logic [17:0] alo, ahi;
  logic done, start, refused, quad, ro1, ro2, ro3;
  int n_mismatch = 0;
  int checks = 0;
  // 100 ns clock
  always #50 i_clk = ~i_clk;
  fswp_host h (.i_clk(i_clk), .o_cmd(cmd), .o_wlow(wlow), .o_whigh(whigh),
    .o_addr_lo(alo), .o_addr_hi(ahi), .o_op_done(done));
  fswp_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_power_cycle(i_power_cycle), .i_cmd(cmd),
    .i_wlow(wlow), .i_whigh(whigh), .i_addr_lo(alo), .i_addr_hi(ahi), .i_op_done(done),
    .i_protect_pin_n(i_protect_pin_n), .o_status_protect_low(low),
    .o_status_control_high(high), .o_op_start(start), .o_op_refused(refused),
    .o_quad_enable(quad), .o_secure_ro_1(ro1), .o_secure_ro_2(ro2), .o_secure_ro_3(ro3));
  // ************************************
  // helpers
  // ************************************
  // compare and count
  task automatic chk(input logic [7:0] seen, exp, input string m);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one command with its same-cycle answer {start, refused}
  task automatic op(input fswp_cmd_t c, input logic [17:0] a, b, input logic [1:0] ans);
    h.send(c, wlow, whigh, a, b);
    chk({6'h00, start, refused}, {6'h00, ans}, "answer");
    h.rel();
  endtask
  // wait for busy to drop, bounded
  task automatic idle();
    int n;
    n = 0;
    repeat (3) @(negedge i_clk);
    while (low[0] !== 1'b0)
    begin
      n++;
      if (n > 100)
      begin
        n_mismatch++;
        results();
      end
      @(negedge i_clk);
    end
    @(negedge i_clk);
  endtask
  // latch then status write of both bytes
  task automatic wsr(input logic [7:0] lo, hi, input logic [1:0] ans);
    op(FSWP_CMD_WEN, 0, 0, 2'b00);
    h.send(FSWP_CMD_WSTAT, lo, hi, 0, 0);
    chk({6'h00, start, refused}, {6'h00, ans}, "wstat");
    h.rel();
    idle();
  endtask
  // supply drop and return
  task automatic pc();
    @(negedge i_clk);
    i_power_cycle = 1'b1;
    @(negedge i_clk);
    i_power_cycle = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    repeat (13) @(negedge i_clk);
    i_rst = 1'b0;
    chk(low, 8'h00, "low rst");
    chk(high, 8'h00, "high rst");
    op(FSWP_CMD_WSTAT, 0, 0, 2'b01);
    op(FSWP_CMD_WEN, 0, 0, 2'b00);
    @(negedge i_clk);
    chk(low, 8'h02, "latch set");
    op(FSWP_CMD_WDIS, 0, 0, 2'b00);
    @(negedge i_clk);
    chk(low, 8'h00, "latch clr");
    $display("test latch done");
    wsr(8'h7F, 8'hCE, 2'b00);
    chk(low, 8'h7C, "bp write");
    chk(high, 8'h4A, "high write");
    chk({4'h0, ro3, ro2, ro1, quad}, 8'h03, "quad lock");
    op(FSWP_CMD_WEN, 0, 0, 2'b00);
    op(FSWP_CMD_PROG, 18'h0, 18'h3FFFF, 2'b10);
    @(negedge i_clk);
    chk(low, 8'h7D, "busy");
    h.done();
    idle();
    chk(low, 8'h7C, "prog end");
    op(FSWP_CMD_WEN, 0, 0, 2'b00);
    op(FSWP_CMD_CHIP, 0, 0, 2'b10);
    h.done();
    idle();
    $display("test program done");
    wsr(8'h44, 8'h40, 2'b00);
    chk(high, 8'h48, "lock kept");
    chk({4'h0, ro3, ro2, ro1, quad}, 8'h02, "quad off");
    op(FSWP_CMD_WEN, 0, 0, 2'b00);
    op(FSWP_CMD_PROG, 18'h3EFFF, 18'h3F000, 2'b01);
    @(negedge i_clk);
    chk(low, 8'h46, "refused idle");
    op(FSWP_CMD_PROG, 18'h3F000, 18'h3FFFF, 2'b10);
    h.done();
    idle();
    op(FSWP_CMD_WEN, 0, 0, 2'b00);
    op(FSWP_CMD_CHIP, 0, 0, 2'b01);
    op(FSWP_CMD_WDIS, 0, 0, 2'b00);
    wsr(8'h04, 8'h08, 2'b00);
    op(FSWP_CMD_WEN, 0, 0, 2'b00);
    op(FSWP_CMD_SECT, 18'h30000, 18'h30FFF, 2'b01);
    op(FSWP_CMD_BLK, 18'h20000, 18'h2FFFF, 2'b10);
    h.done();
    idle();
    $display("test region done");
    op(FSWP_CMD_ESUS, 0, 0, 2'b00);
    op(FSWP_CMD_PSUS, 0, 0, 2'b00);
    @(negedge i_clk);
    chk(high, 8'h8C, "susp set");
    op(FSWP_CMD_RES, 0, 0, 2'b00);
    @(negedge i_clk);
    chk(high, 8'h08, "resume");
    op(FSWP_CMD_ESUS, 0, 0, 2'b00);
    op(FSWP_CMD_SRST, 0, 0, 2'b00);
    @(negedge i_clk);
    chk(high, 8'h08, "soft rst");
    $display("test suspend done");
    wsr(8'h80, 8'h08, 2'b00);
    i_protect_pin_n = 1'b0;
    repeat (4) @(negedge i_clk);
    wsr(8'h84, 8'h08, 2'b01);
    chk(low, 8'h82, "pin lock");
    i_protect_pin_n = 1'b1;
    repeat (4) @(negedge i_clk);
    wsr(8'h00, 8'h09, 2'b00);
    wsr(8'h80, 8'h08, 2'b01);
    chk(low, 8'h02, "lockdown");
    pc();
    chk(low, 8'h00, "pc low");
    chk(high, 8'h08, "pc high");
    i_protect_pin_n = 1'b0;
    repeat (4) @(negedge i_clk);
    wsr(8'h80, 8'h09, 2'b00);
    wsr(8'h00, 8'h08, 2'b01);
    pc();
    chk(high, 8'h09, "otp high");
    chk(low, 8'h80, "otp low");
    $display("test guard done");
    results();
  end
endmodule
